// ==== core/sobd_defs.vh ====
// Constants for the static option byte decoder
`ifndef SOBD_DEFS_VH
`define SOBD_DEFS_VH
`define SOBD_OPT_WIDTH 8
`define SOBD_ERASED_BYTE 8'hff
`define SOBD_BIT_PROTECT 0
`define SOBD_BIT_FIXED_ONE 1
`define SOBD_BIT_RETRY 2
`define SOBD_BIT_CLKSRC 3
`define SOBD_BIT_NESTED_IRQ_ENABLE 4
`define SOBD_BIT_WDG 5
`define SOBD_RETRY_LOW 3'h4
`define SOBD_RETRY_HIGH 3'h5
`define SOBD_CARD_DIV 4'hc
`define SOBD_ADDR_OPTION 12'h000
`define SOBD_ADDR_STATUS 12'h004
`define SOBD_ADDR_CONTROL 12'h008
`define SOBD_ST_IDLE 2'h0
`define SOBD_ST_ERASE 2'h1
`define SOBD_ST_OPT 2'h2
`define SOBD_RESP_OKAY 2'h0
`define SOBD_RESP_SLVERR 2'h2
`endif

// ==== core/sobd_top.v ====
// Static option byte capture, decode, card clock divider and AXI4-Lite view
// Contract
// R1: Take eight option bits as one byte
// R2: Bit5 zero forces watchdog on always (WATCHDOG_ACTIVE stays low in reset and until captured_q sets one cycle later)
// R3: Bit4 enables nested interrupt controller
// R4: Bit3 selects card clock: divider or oscillator
// R5: Bit2 sets transmit count four or five
// R6: Programmer keeps bit1 one; 7:6 reserved
// R7: Bit0 zero enables read-out protection
// R8: Protection blocks test and in-circuit access
// R9: Unprotect erase wipes user memory first
// R10: Blank flash and option byte read ones
// R11: Capture once at reset, hold until next
//
// Decided for this implementation: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/10ps
`include "sobd_defs.vh"
module sobd_top #(
   parameter ERASE_WAIT = 16
) (
   input wire CLK_SYS,
   input wire RST,
   input wire [7:0] NVM_OPTION_BYTE,
   input wire NVM_OPTION_PROGRAMMED,
   input wire CLK_48M_TICK,
   input wire CLK_OSC_TICK,
   input wire TEST_MODE,
   input wire ICP_MODE,
   input wire WDG_SW_START,
   output wire WATCHDOG_ACTIVE,
   output wire WATCHDOG_TYPE_SELECT,
   output wire NESTED_IRQ_ENABLE,
   output wire CARD_CLOCK_SOURCE_SELECT,
   output wire CARD_CLK_TICK,
   output wire [2:0] CARD_TX_ATTEMPTS,
   output wire READOUT_PROTECT,
   output wire EXT_ACCESS_ALLOW,
   output wire USER_ERASE_REQ,
   output wire OPTION_ERASE_REQ,
   input wire ERASE_DONE,
   input wire [11:0] S_AXI_AWADDR,
   input wire S_AXI_AWVALID,
   output wire S_AXI_AWREADY,
   input wire [31:0] S_AXI_WDATA,
   input wire [3:0] S_AXI_WSTRB,
   input wire S_AXI_WVALID,
   output wire S_AXI_WREADY,
   output wire [1:0] S_AXI_BRESP,
   output wire S_AXI_BVALID,
   input wire S_AXI_BREADY,
   input wire [11:0] S_AXI_ARADDR,
   input wire S_AXI_ARVALID,
   output wire S_AXI_ARREADY,
   output wire [31:0] S_AXI_RDATA,
   output wire [1:0] S_AXI_RRESP,
   output wire S_AXI_RVALID,
   input wire S_AXI_RREADY
);
   ////////////////////////////////////////////////////////////////////////////
   reg [7:0] opt_q;
   reg captured_q;
   reg wdg_run_q;
   reg [3:0] div_q;
   reg card_tick_q;
   reg [1:0] st_q;
   reg [15:0] wait_q;
   reg user_erase_q;
   reg opt_erase_q;
   reg erase_busy_q;
   // Options come from a live flash macro; a byte still blank reads as ones
   wire [7:0] src_byte = NVM_OPTION_PROGRAMMED ? NVM_OPTION_BYTE : `SOBD_ERASED_BYTE; // [R10]

   // Sampled only on the first cycle after reset so later flash writes never leak in
   always @(posedge CLK_SYS) begin
      if (RST) begin
         opt_q <= `SOBD_ERASED_BYTE;
         captured_q <= 1'b0;
      end else if (!captured_q) begin
         opt_q <= src_byte; // [R1] [R11]
         captured_q <= 1'b1;
      end
   end

   assign WATCHDOG_TYPE_SELECT = opt_q[`SOBD_BIT_WDG];
   // Software start is sticky: only reset stops a started watchdog
   always @(posedge CLK_SYS) begin
      if (RST)
         wdg_run_q <= 1'b0;
      else if (captured_q && WDG_SW_START)
         wdg_run_q <= 1'b1;
   end
   assign WATCHDOG_ACTIVE = captured_q && (!opt_q[`SOBD_BIT_WDG] || wdg_run_q); // [R2]
   assign NESTED_IRQ_ENABLE = opt_q[`SOBD_BIT_NESTED_IRQ_ENABLE]; // [R3]
   assign CARD_TX_ATTEMPTS = opt_q[`SOBD_BIT_RETRY] ? `SOBD_RETRY_HIGH : `SOBD_RETRY_LOW; // [R5]
   assign READOUT_PROTECT = !opt_q[`SOBD_BIT_PROTECT]; // [R7]
   // Bit1 and bits 7:6 are not decoded; a wrong bit1 only shows in the readback
   assign EXT_ACCESS_ALLOW = !(READOUT_PROTECT && (TEST_MODE || ICP_MODE)); // [R8]

   ////////////////////////////////////////////////////////////////////////////
   // Card clock: tick enables, so no derived clock net is created
   always @(posedge CLK_SYS) begin
      if (RST) begin
         div_q <= 4'h0;
         card_tick_q <= 1'b0;
      end else if (opt_q[`SOBD_BIT_CLKSRC]) begin
         div_q <= 4'h0;
         card_tick_q <= CLK_OSC_TICK; // [R4]
      end else if (CLK_48M_TICK) begin
         if (div_q == `SOBD_CARD_DIV - 4'h1) begin
            div_q <= 4'h0;
            card_tick_q <= 1'b1; // [R4]
         end else begin
            div_q <= div_q + 4'h1;
            card_tick_q <= 1'b0;
         end
      end else
         card_tick_q <= 1'b0;
   end
   assign CARD_CLOCK_SOURCE_SELECT = opt_q[`SOBD_BIT_CLKSRC];
   assign CARD_CLK_TICK = card_tick_q;

   ////////////////////////////////////////////////////////////////////////////
   // Option erase sequencer: with protection on, user memory goes first
   wire erase_cmd;
   always @(posedge CLK_SYS) begin
      if (RST) begin
         st_q <= `SOBD_ST_IDLE;
         user_erase_q <= 1'b0;
         opt_erase_q <= 1'b0;
         wait_q <= 16'h0000;
      end else begin
         case (st_q)
            `SOBD_ST_IDLE: begin
               if (erase_cmd) begin
                  wait_q <= 16'h0000;
                  if (READOUT_PROTECT) begin
                     st_q <= `SOBD_ST_ERASE;
                     user_erase_q <= 1'b1; // [R9]
                  end else begin
                     st_q <= `SOBD_ST_OPT;
                     opt_erase_q <= 1'b1;
                  end
               end
            end
            `SOBD_ST_ERASE: begin
               // Hold the request until the flash reports done, with a floor of ERASE_WAIT cycles
               if (wait_q != ERASE_WAIT[15:0])
                  wait_q <= wait_q + 16'h0001;
               if (ERASE_DONE && wait_q == ERASE_WAIT[15:0]) begin
                  user_erase_q <= 1'b0;
                  opt_erase_q <= 1'b1; // [R9]
                  st_q <= `SOBD_ST_OPT;
               end
            end
            `SOBD_ST_OPT: begin
               if (ERASE_DONE) begin
                  opt_erase_q <= 1'b0;
                  st_q <= `SOBD_ST_IDLE;
               end
            end
            default: st_q <= `SOBD_ST_IDLE;
         endcase
      end
   end
   assign USER_ERASE_REQ = user_erase_q;
   assign OPTION_ERASE_REQ = opt_erase_q;
   always @* erase_busy_q = (st_q != `SOBD_ST_IDLE);

   ////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite slave: one write and one read outstanding, address and data in any order
   reg aw_got_q, w_got_q, bvalid_q, rvalid_q;
   reg [11:0] awaddr_q;
   reg [31:0] wdata_q, rdata_q;
   reg [3:0] wstrb_q;
   reg [1:0] bresp_q, rresp_q;
   reg erase_cmd_q;

   function addr_ok;
      input [11:0] a;
      begin
         addr_ok = (a == `SOBD_ADDR_OPTION) || (a == `SOBD_ADDR_STATUS) || (a == `SOBD_ADDR_CONTROL);
      end
   endfunction

   assign S_AXI_AWREADY = !aw_got_q && !bvalid_q;
   assign S_AXI_WREADY = !w_got_q && !bvalid_q;
   wire aw_now = aw_got_q || S_AXI_AWVALID;
   wire w_now = w_got_q || S_AXI_WVALID;
   wire [11:0] aw_eff = aw_got_q ? awaddr_q : S_AXI_AWADDR;
   wire [31:0] w_eff = w_got_q ? wdata_q : S_AXI_WDATA;
   wire [3:0] s_eff = w_got_q ? wstrb_q : S_AXI_WSTRB;
   wire do_write = aw_now && w_now && !bvalid_q;
   assign erase_cmd = erase_cmd_q;

   always @(posedge CLK_SYS) begin
      if (RST) begin
         aw_got_q <= 1'b0;
         w_got_q <= 1'b0;
         awaddr_q <= 12'h000;
         wdata_q <= 32'h00000000;
         wstrb_q <= 4'h0;
         bvalid_q <= 1'b0;
         bresp_q <= `SOBD_RESP_OKAY;
         erase_cmd_q <= 1'b0;
      end else begin
         erase_cmd_q <= 1'b0;
         if (do_write) begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            bvalid_q <= 1'b1;
            bresp_q <= addr_ok(aw_eff) ? `SOBD_RESP_OKAY : `SOBD_RESP_SLVERR;
            if (aw_eff == `SOBD_ADDR_CONTROL && s_eff[0] && w_eff[0] && !erase_busy_q)
               erase_cmd_q <= 1'b1;
         end else begin
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
               aw_got_q <= 1'b1;
               awaddr_q <= S_AXI_AWADDR;
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
               w_got_q <= 1'b1;
               wdata_q <= S_AXI_WDATA;
               wstrb_q <= S_AXI_WSTRB;
            end
            if (bvalid_q && S_AXI_BREADY)
               bvalid_q <= 1'b0;
         end
      end
   end

   assign S_AXI_ARREADY = !rvalid_q;
   always @(posedge CLK_SYS) begin
      if (RST) begin
         rvalid_q <= 1'b0;
         rdata_q <= 32'h00000000;
         rresp_q <= `SOBD_RESP_OKAY;
      end else if (S_AXI_ARVALID && !rvalid_q) begin
         rvalid_q <= 1'b1;
         rresp_q <= addr_ok(S_AXI_ARADDR) ? `SOBD_RESP_OKAY : `SOBD_RESP_SLVERR;
         case (S_AXI_ARADDR)
            `SOBD_ADDR_OPTION: rdata_q <= {24'h000000, opt_q};
            `SOBD_ADDR_STATUS: rdata_q <= {26'h0, erase_busy_q, EXT_ACCESS_ALLOW,
               READOUT_PROTECT, WATCHDOG_ACTIVE, opt_q[`SOBD_BIT_FIXED_ONE], captured_q};
            default: rdata_q <= 32'h00000000;
         endcase
      end else if (rvalid_q && S_AXI_RREADY)
         rvalid_q <= 1'b0;
   end
   assign S_AXI_BVALID = bvalid_q;
   assign S_AXI_BRESP = bresp_q;
   assign S_AXI_RVALID = rvalid_q;
   assign S_AXI_RDATA = rdata_q;
   assign S_AXI_RRESP = rresp_q;
endmodule

// ==== tb/sobd_assertions.sv ====
// Checker for the option byte decoder outputs
`timescale 1ns/10ps
module sobd_assertions (
   input wire CLK_SYS,
   input wire RST,
   input wire [7:0] NVM_OPTION_BYTE,
   input wire NVM_OPTION_PROGRAMMED,
   input wire CLK_OSC_TICK,
   input wire TEST_MODE,
   input wire ICP_MODE,
   input wire WDG_SW_START,
   input wire WATCHDOG_ACTIVE,
   input wire NESTED_IRQ_ENABLE,
   input wire CARD_CLOCK_SOURCE_SELECT,
   input wire CARD_CLK_TICK,
   input wire [2:0] CARD_TX_ATTEMPTS,
   input wire READOUT_PROTECT,
   input wire EXT_ACCESS_ALLOW,
   input wire USER_ERASE_REQ,
   input wire OPTION_ERASE_REQ
);
reg [1:0] age_q;
reg [7:0] opt_q;
reg go_q;
reg ue_q;
// Decodes are only judged once capture has settled
wire rdy = age_q == 2'h3;
always @(posedge CLK_SYS) begin
   if (RST) begin
      age_q <= 2'h0;
      go_q <= 1'b0;
      ue_q <= 1'b0;
   end else begin
      if (age_q == 2'h0) opt_q <= NVM_OPTION_PROGRAMMED ? NVM_OPTION_BYTE : 8'hff;
      if (age_q != 2'h3) age_q <= age_q + 2'h1;
      if (WDG_SW_START) go_q <= 1'b1;
      if (USER_ERASE_REQ) ue_q <= 1'b1;
   end
end
default clocking @(posedge CLK_SYS); endclocking
default disable iff (RST);
sequence s_osc_out;
   ##1 CARD_CLK_TICK;
endsequence
a_retry_count: assert property (rdy |-> CARD_TX_ATTEMPTS == (opt_q[2] ? 3'h5 : 3'h4))
   else $error("attempt count wrong");
a_nested_irq_enable_enable: assert property (rdy |-> NESTED_IRQ_ENABLE == opt_q[4])
   else $error("nesting enable wrong");
a_clock_select: assert property (rdy |-> CARD_CLOCK_SOURCE_SELECT == opt_q[3])
   else $error("card clock select wrong");
a_protect_level: assert property (rdy |-> READOUT_PROTECT == !opt_q[0])
   else $error("protect level wrong");
a_access_block: assert property (rdy |-> EXT_ACCESS_ALLOW == !(!opt_q[0] && (TEST_MODE || ICP_MODE)))
   else $error("external access wrong");
a_wdg_hard: assert property (rdy && !opt_q[5] |-> WATCHDOG_ACTIVE)
   else $error("hardware watchdog idle");
a_wdg_soft: assert property (rdy && opt_q[5] && !go_q && !WDG_SW_START |-> !WATCHDOG_ACTIVE)
   else $error("software watchdog ran early");
a_wdg_start: assert property (rdy && opt_q[5] && WDG_SW_START |-> ##[1:2] WATCHDOG_ACTIVE)
   else $error("software watchdog not started");
a_osc_pass: assert property (rdy && opt_q[3] && CLK_OSC_TICK |-> s_osc_out)
   else $error("oscillator tick lost");
a_erase_first: assert property ($rose(OPTION_ERASE_REQ) && READOUT_PROTECT |-> ue_q)
   else $error("user memory not erased first");
a_erase_apart: assert property (!(USER_ERASE_REQ && OPTION_ERASE_REQ))
   else $error("both erases at once");
endmodule
bind sobd_top sobd_assertions sobd_assertions_i (.CLK_SYS(CLK_SYS), .RST(RST), .NVM_OPTION_BYTE(NVM_OPTION_BYTE),
   .NVM_OPTION_PROGRAMMED(NVM_OPTION_PROGRAMMED), .CLK_OSC_TICK(CLK_OSC_TICK), .TEST_MODE(TEST_MODE),
   .ICP_MODE(ICP_MODE), .WDG_SW_START(WDG_SW_START), .WATCHDOG_ACTIVE(WATCHDOG_ACTIVE),
   .NESTED_IRQ_ENABLE(NESTED_IRQ_ENABLE), .CARD_CLOCK_SOURCE_SELECT(CARD_CLOCK_SOURCE_SELECT),
   .CARD_CLK_TICK(CARD_CLK_TICK), .CARD_TX_ATTEMPTS(CARD_TX_ATTEMPTS), .READOUT_PROTECT(READOUT_PROTECT),
   .EXT_ACCESS_ALLOW(EXT_ACCESS_ALLOW), .USER_ERASE_REQ(USER_ERASE_REQ), .OPTION_ERASE_REQ(OPTION_ERASE_REQ));

// ==== tb/static_option_byte_decoder_test.sv ====
// Randomised bench for the option byte decoder
`timescale 1ns/10ps
module static_option_byte_decoder_test;
reg clk, rst, prog, t48, tosc, tm, im, wst, ed, awv, wv, bry, arv, rry, seen, v;
reg [7:0] nvm, opt;
reg [11:0] awa, ara;
reg [31:0] wd, rd;
reg [1:0] rs;
wire [31:0] rdata;
wire [2:0] tx;
wire [1:0] bresp, rresp;
wire wact, wsel, nested_irq_enable, csel, ct, prot, allow, ureq, oreq, awr, wr, bv, arr, rv;
integer num_errors, total_checks, i, j, n, e;
sobd_top #(.ERASE_WAIT(2)) sobd_top_i (.CLK_SYS(clk), .RST(rst), .NVM_OPTION_BYTE(nvm),
   .NVM_OPTION_PROGRAMMED(prog), .CLK_48M_TICK(t48), .CLK_OSC_TICK(tosc), .TEST_MODE(tm), .ICP_MODE(im),
   .WDG_SW_START(wst), .WATCHDOG_ACTIVE(wact), .WATCHDOG_TYPE_SELECT(wsel), .NESTED_IRQ_ENABLE(nested_irq_enable),
   .CARD_CLOCK_SOURCE_SELECT(csel), .CARD_CLK_TICK(ct), .CARD_TX_ATTEMPTS(tx), .READOUT_PROTECT(prot),
   .EXT_ACCESS_ALLOW(allow), .USER_ERASE_REQ(ureq), .OPTION_ERASE_REQ(oreq), .ERASE_DONE(ed),
   .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hf),
   .S_AXI_WVALID(wv), .S_AXI_WREADY(wr), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv), .S_AXI_BREADY(bry),
   .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
   .S_AXI_RVALID(rv), .S_AXI_RREADY(rry));
//////////////////////////////////////////
function [2:0] tries(input [7:0] o);
   tries = o[2] ? 3'h5 : 3'h4;
endfunction
task check(input [31:0] got, input [31:0] exp);
   begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
         num_errors = num_errors + 1;
         $display("wrong value at %0t: seen %h expected %h", $time, got, exp);
      end
   end
endtask
task test_done;
   begin
      if (num_errors == 0 && total_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   end
endtask
// Both AXI tasks start and end on a rising edge
task axi_wr(input [11:0] a, input [31:0] d);
   begin
      awa <= a;
      wd <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      bry <= 1'b1;
      seen = 0;
      while (!seen) begin
         @(posedge clk);
         if (awr === 1'b1) awv <= 1'b0;
         if (wr === 1'b1) wv <= 1'b0;
         seen = bv === 1'b1;
      end
      rs = bresp;
      bry <= 1'b0;
      @(posedge clk);
   end
endtask
task axi_rd(input [11:0] a);
   begin
      ara <= a;
      arv <= 1'b1;
      rry <= 1'b1;
      seen = 0;
      while (!seen) begin
         @(posedge clk);
         if (arr === 1'b1) arv <= 1'b0;
         seen = rv === 1'b1;
      end
      rd = rdata;
      rs = rresp;
      rry <= 1'b0;
      @(posedge clk);
   end
endtask
// Flash finishes well after the minimum erase wait
task done_pulse;
   begin
      repeat (4) @(posedge clk);
      ed <= 1'b1;
      @(posedge clk);
      ed <= 1'b0;
   end
endtask
//////////////////////////////////////////
initial begin
   clk = 0;
   forever #2.5 clk = ~clk;
end
initial begin
   #200000;
   num_errors = num_errors + 1;
   test_done;
end
initial begin
   {rst, prog, t48, tosc, tm, im, wst, ed, awv, wv, bry, arv, rry} = 13'h1000;
   {nvm, awa, ara, wd} = 64'h0;
   num_errors = 0;
   total_checks = 0;
   i = $urandom(32'h62463322);
   for (i = 0; i < 12; i = i + 1) begin
      @(posedge clk);
      nvm <= (i == 0) ? 8'h02 : ((i == 1) ? 8'hff : ($urandom | 8'h02));
      prog <= (i != 2);
      rst <= 1'b1;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      repeat (3) @(posedge clk);
      opt = prog ? nvm : 8'hff;
      // Flash content that moves after capture must never reach the decodes
      nvm <= ~nvm;
      check(tx, tries(opt));
      check({wsel, nested_irq_enable, csel, prot}, {opt[5:3], ~opt[0]});
      check(wact, !opt[5]);
      tm <= $urandom;
      im <= $urandom;
      wst <= 1'b1;
      @(posedge clk);
      wst <= 1'b0;
      check(allow, !(!opt[0] && (tm || im)));
      repeat (2) @(posedge clk);
      check(wact, 1'b1);
      axi_rd(12'h004);
      check(rd, {26'h0, 1'b0, !(!opt[0] && (tm || im)), !opt[0], 1'b1, opt[1], 1'b1});
      axi_rd(12'h000);
      check(rd, {24'h0, opt});
      axi_wr(12'h000, $urandom);
      check(rs, 2'h0);
      axi_rd(12'h00c);
      check(rs, 2'h2);
      check(rd, 32'h0);
      n = 0;
      e = 0;
      for (j = 0; j < 28; j = j + 1) begin
         @(posedge clk);
         n = n + (ct === 1'b1);
         v = (j < 24) ? $urandom : 1'b0;
         e = e + v;
         t48 <= (j < 24);
         tosc <= v;
      end
      check(n, opt[3] ? e : 2);
      axi_wr(12'h008, 32'h1);
      check(rs, 2'h0);
      while (ureq !== 1'b1 && oreq !== 1'b1) @(posedge clk);
      check(ureq, !opt[0]);
      if (ureq === 1'b1) begin
         done_pulse;
         while (oreq !== 1'b1) @(posedge clk);
      end
      done_pulse;
      while (oreq === 1'b1) @(posedge clk);
      axi_rd(12'h000);
      check(rd, {24'h0, opt});
   end
   test_done;
end
endmodule
